// file: hdl/wsp_pkg.sv
/*
 * constants for the segment playback controller.
 * assumes one sample clock (pclk) and an apb register port.
 */
package wsp_pkg;
   // ====================================
   // sizes
   localparam int SEG_W = 14;
   localparam int SEG_N = 16384;
   localparam int ADDR_W = 16;
   localparam int WAV_N = 65536;
   localparam int SMP_W = 12;
   localparam int EXT_W = 8;
   localparam int LOOP_W = 20;
   localparam int CH_N = 2;
   // ====================================
   // register offsets
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_SEG = 8'h04;
   localparam logic [7:0] OFS_LOOPS = 8'h08;
   localparam logic [7:0] OFS_CMD = 8'h0c;
   localparam logic [7:0] OFS_TIDX = 8'h10;
   localparam logic [7:0] OFS_BOUNDS = 8'h14;
   localparam logic [7:0] OFS_WADDR = 8'h18;
   localparam logic [7:0] OFS_WDATA = 8'h1c;
   localparam logic [7:0] OFS_STATUS = 8'h20;
   // ====================================
   // control fields
   localparam int C_MODE = 0;
   localparam int C_ARMED = 2;
   localparam int C_EXT = 3;
   localparam int C_IMM = 4;
   localparam int C_INIT = 5;
   localparam int C_EVT = 7;
   localparam logic [7:0] CTRL_RST = 8'h00;
   localparam logic [LOOP_W-1:0] LOOPS_RST = 20'h00001;
   localparam logic [LOOP_W-1:0] LOOPS_MAX = 20'hf4240;
   // command bits
   localparam int K_EN = 0;
   localparam int K_ABORT = 1;
   localparam int K_INIT = 2;
   localparam int K_DEL = 3;
   // synchronised pin vector
   localparam int P_IDX0 = 0;
   localparam int P_IDX1 = 8;
   localparam int P_VAL0 = 16;
   localparam int P_TRIG = 18;
   localparam int P_GATE = 19;
   localparam int P_EVT = 20;
   localparam int P_BTN = 21;
   localparam int PIN_W = 22;
   // ====================================
   typedef enum logic [1:0] {RM_CONT, RM_TRIG, RM_GATE} run_mode_type;
   typedef enum logic [1:0] {IS_PANEL, IS_BUS, IS_TRIG} init_src_type;
   typedef enum logic {ST_IDLE, ST_PLAY} play_st_type;
endpackage

// file: hdl/wave_seg_play.sv
/*
 * segment playback controller: segment table, sample memory, run modes,
 * and two external segment-select inputs, all on the sample clock pclk.
 * assumes an apb master and asynchronous pin inputs.
 */
// Chosen here: the register offsets and the APB slave port.
`timescale 1ns/1ps
module wave_seg_play
   import wsp_pkg::*;
(
   // clock, reset, enable
   input wire logic pclk,
   input wire logic presetn,
   input wire logic ce,
   // apb
   input wire logic [7:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // external segment select
   input wire logic [wsp_pkg::EXT_W-1:0] ext_idx0,
   input wire logic ext_valid0,
   input wire logic [wsp_pkg::EXT_W-1:0] ext_idx1,
   input wire logic ext_valid1,
   // run control pins
   input wire logic trig_in,
   input wire logic gate_in,
   input wire logic event_in,
   input wire logic button_in,
   // converter path
   output logic [wsp_pkg::SMP_W-1:0] smp0,
   output logic [wsp_pkg::SMP_W-1:0] smp1,
   output logic playing
);
   import wsp_pkg::*;

   // ====================================
   // state
   typedef struct packed {
      logic [7:0] ctrl;
      logic [SEG_W-1:0] seg;
      logic [LOOP_W-1:0] loops;
      logic [SEG_W-1:0] tidx;
      logic [ADDR_W-1:0] waddr;
      logic [PIN_W-1:0] s1;
      logic [PIN_W-1:0] s2;
      logic [PIN_W-1:0] s3;
      logic [CH_N-1:0][EXT_W-1:0] ext;
      logic [CH_N-1:0][SEG_W-1:0] cur;
      logic [CH_N-1:0][ADDR_W-1:0] addr;
      logic [CH_N-1:0][SMP_W-1:0] smp;
      play_st_type st;
      logic en;
      logic [LOOP_W-1:0] left;
      logic [31:0] rdata;
   } state_type;

   state_type state_r;
   state_type state_nxt;

   // ====================================
   // memories
   logic [ADDR_W-1:0] tbl_start [SEG_N];
   logic [ADDR_W-1:0] tbl_stop [SEG_N];
   logic [SEG_N-1:0] tbl_ok;
   logic [SMP_W-1:0] wav [WAV_N];

   logic wr;
   logic [3:0] cmd;
   logic armed;
   logic go_ok;
   logic init_ev;
   logic en_ev;
   logic mapped;
   run_mode_type mode;
   logic [PIN_W-1:0] rise;
   logic [CH_N-1:0] wrap;
   logic [CH_N-1:0][SEG_W-1:0] want;
   // start address of the wanted segment; an undefined entry starts at zero
   logic [CH_N-1:0][ADDR_W-1:0] first;
   // end of the current segment; an undefined entry ends at once
   logic [CH_N-1:0] stop_hit;

   assign pready = ce;
   assign pslverr = psel & penable & ~mapped;
   assign prdata = state_r.rdata;
   assign smp0 = state_r.smp[0];
   assign smp1 = state_r.smp[1];
   assign playing = state_r.st == ST_PLAY;

   always_comb begin
      case (paddr)
         OFS_CTRL, OFS_SEG, OFS_LOOPS, OFS_CMD, OFS_TIDX, OFS_BOUNDS,
         OFS_WADDR, OFS_WDATA, OFS_STATUS: mapped = 1'b1;
         default: mapped = 1'b0;
      endcase
   end

   // ====================================
   // next state
   always_comb begin
      state_nxt = state_r;
      wr = psel & penable & pwrite & ce;
      cmd = (wr && paddr == OFS_CMD) ? pwdata[3:0] : 4'h0;
      armed = state_r.ctrl[C_ARMED];
      mode = run_mode_type'(state_r.ctrl[C_MODE+:2]);
      rise = state_r.s2 & ~state_r.s3;
      wrap = '0;
      want = '0;
      first = '0;
      stop_hit = '0;
      // pins pass two flops before use
      state_nxt.s1 = {button_in, event_in, gate_in, trig_in, ext_valid1,
                      ext_valid0, ext_idx1, ext_idx0};
      state_nxt.s2 = state_r.s1;
      state_nxt.s3 = state_r.s2;

      // register writes; any segment index is taken as is
      if (wr) begin
         case (paddr)
            OFS_CTRL: state_nxt.ctrl = pwdata[7:0];
            OFS_SEG: state_nxt.seg = pwdata[SEG_W-1:0];
            OFS_LOOPS: begin
               if (pwdata[LOOP_W-1:0] == '0) begin
                  state_nxt.loops = LOOPS_RST;
               end else if (pwdata[LOOP_W-1:0] > LOOPS_MAX) begin
                  state_nxt.loops = LOOPS_MAX;
               end else begin
                  state_nxt.loops = pwdata[LOOP_W-1:0];
               end
            end
            OFS_TIDX: state_nxt.tidx = pwdata[SEG_W-1:0];
            OFS_WADDR: state_nxt.waddr = pwdata[ADDR_W-1:0];
            OFS_WDATA: state_nxt.waddr = state_r.waddr + 16'h0001;
            default: ;
         endcase
      end

      // read data is latched in the setup phase
      if (psel && !penable) begin
         case (paddr)
            OFS_CTRL: state_nxt.rdata = {24'h0, state_r.ctrl};
            OFS_SEG: state_nxt.rdata = {18'h0, state_r.seg};
            OFS_LOOPS: state_nxt.rdata = {12'h0, state_r.loops};
            OFS_TIDX: state_nxt.rdata = {18'h0, state_r.tidx};
            OFS_BOUNDS: state_nxt.rdata = {tbl_stop[state_r.tidx],
                                           tbl_start[state_r.tidx]};
            OFS_WADDR: state_nxt.rdata = {16'h0, state_r.waddr};
            OFS_STATUS: state_nxt.rdata = {2'h0, state_r.cur[1],
                                           state_r.cur[0], state_r.en,
                                           playing};
            default: state_nxt.rdata = 32'h0;
         endcase
      end

      // per channel select and playback
      for (int c = 0; c < CH_N; c++) begin
         // index captured on valid rise only
         if (rise[P_VAL0+c]) begin
            state_nxt.ext[c] = state_r.s2[c*EXT_W+:EXT_W];
         end
         // external source, else bus command
         want[c] = state_r.ctrl[C_EXT] ? {6'h0, state_r.ext[c]} : state_r.seg;
         // bounds memory has no reset, so only defined entries are trusted
         first[c] = tbl_ok[want[c]] ? tbl_start[want[c]] : 16'h0000;
         stop_hit[c] = !tbl_ok[state_r.cur[c]]
                       || state_r.addr[c] == tbl_stop[state_r.cur[c]];
         if (state_r.st == ST_IDLE) begin
            // idle holds the first point
            state_nxt.cur[c] = want[c];
            state_nxt.addr[c] = first[c];
         end else if (state_r.ctrl[C_IMM] && want[c] != state_r.cur[c]) begin
            state_nxt.cur[c] = want[c];
            state_nxt.addr[c] = first[c];
         end else if (stop_hit[c]) begin
            wrap[c] = 1'b1;
            state_nxt.cur[c] = want[c];
            state_nxt.addr[c] = first[c];
         end else begin
            state_nxt.addr[c] = state_r.addr[c] + 16'h0001;
         end
         // only a defined active segment reaches the output
         state_nxt.smp[c] = tbl_ok[state_r.cur[c]] ? wav[state_r.addr[c]]
                                                   : 12'h000;
      end

      // enable and initiate sources
      en_ev = state_r.ctrl[C_EVT] ? rise[P_EVT] : cmd[K_EN];
      case (init_src_type'(state_r.ctrl[C_INIT+:2]))
         IS_PANEL: init_ev = rise[P_BTN];
         IS_BUS: init_ev = cmd[K_INIT];
         IS_TRIG: init_ev = rise[P_TRIG];
         default: init_ev = 1'b0;
      endcase
      if (armed && en_ev) begin
         state_nxt.en = 1'b1;
      end
      go_ok = !armed || state_r.en;

      case (mode)
         RM_TRIG: begin
            if (state_r.st == ST_IDLE) begin
               if (init_ev && go_ok) begin
                  state_nxt.st = ST_PLAY;
                  state_nxt.left = armed ? state_r.loops : LOOPS_RST;
               end
            end else if (wrap[0]) begin
               if (state_r.left <= LOOPS_RST) begin
                  state_nxt.st = ST_IDLE;
               end else begin
                  state_nxt.left = state_r.left - 20'h00001;
               end
            end
         end
         RM_GATE: begin
            state_nxt.st = (go_ok && state_r.s2[P_GATE]) ? ST_PLAY : ST_IDLE;
         end
         default: begin
            state_nxt.st = go_ok ? ST_PLAY : ST_IDLE;
         end
      endcase

      if (armed && cmd[K_ABORT]) begin
         state_nxt.en = 1'b0;
         state_nxt.st = ST_IDLE;
      end
   end

   // ====================================
   // registers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_r <= '0;
         state_r.ctrl <= CTRL_RST;
         state_r.loops <= LOOPS_RST;
         state_r.st <= ST_IDLE;
      end else if (ce) begin
         state_r <= state_nxt;
      end
   end

   // table and sample memory; delete leaves samples alone
   always_ff @(posedge pclk) begin
      if (wr && paddr == OFS_BOUNDS) begin
         tbl_start[state_r.tidx] <= pwdata[15:0];
         tbl_stop[state_r.tidx] <= pwdata[31:16];
      end
      if (wr && paddr == OFS_WDATA) begin
         wav[state_r.waddr] <= pwdata[SMP_W-1:0];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tbl_ok <= '0;
      end else if (cmd[K_DEL]) begin
         tbl_ok <= '0;
      end else if (wr && paddr == OFS_BOUNDS) begin
         tbl_ok[state_r.tidx] <= 1'b1;
      end
   end

   // ====================================
   // checks
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   a_abort_stops: assert property (ce && armed && cmd[K_ABORT] |=> !playing)
      else $error("armed abort did not stop output");
   a_free_runs: assert property (ce && !armed && mode == RM_CONT |=> playing)
      else $error("free continuous output not running");
   a_gate_idle: assert property (ce && mode == RM_GATE && !state_r.s2[P_GATE]
      |=> !playing)
      else $error("output ran with gate low");
   a_ext_take: assert property (ce && rise[P_VAL0]
      |=> state_r.ext[0] == $past(state_r.s2[EXT_W-1:0]))
      else $error("index not taken on valid rise");
   a_ext_hold: assert property (!(ce && rise[P_VAL0]) |=> $stable(state_r.ext[0]))
      else $error("index changed without valid");
   a_silent_seg: assert property (ce && !tbl_ok[state_r.cur[0]] |=> smp0 == 12'h000)
      else $error("undefined segment produced samples");
   a_idle_first: assert property (ce && state_r.st == ST_IDLE && !wr
      |=> state_r.addr[0] == (tbl_ok[state_r.cur[0]] ? tbl_start[state_r.cur[0]]
                                                      : 16'h0000))
      else $error("idle not on first point");
   a_idle_first1: assert property (ce && state_r.st == ST_IDLE && !wr
      |=> state_r.addr[1] == (tbl_ok[state_r.cur[1]] ? tbl_start[state_r.cur[1]]
                                                      : 16'h0000))
      else $error("idle not on first point, channel one");
   a_delete_clears: assert property (ce && cmd[K_DEL] |=> tbl_ok == '0)
      else $error("delete left table entries defined");
   a_trig_once: assert property (ce && mode == RM_TRIG && playing && wrap[0]
      && state_r.left == LOOPS_RST && !wr |=> !playing)
      else $error("triggered burst did not end");
   a_imm_switch: assert property (ce && playing && state_r.ctrl[C_IMM]
      && want[1] != state_r.cur[1] |=> state_r.cur[1] == $past(want[1]))
      else $error("immediate switch late");

   c_trig_burst: cover property (mode == RM_TRIG && !playing ##1 playing);
   c_ext_select: cover property (state_r.ctrl[C_EXT] && rise[P_VAL0+1]);
   c_coherent: cover property (playing && wrap[0] && want[0] != state_r.cur[0]);
   c_delete: cover property (cmd[K_DEL]);
   c_gate_run: cover property (mode == RM_GATE && playing);
endmodule

// file: verification/seg_src_model.sv
/* far-side model: segment-select controller plus trigger and gate source.
   assumes its tasks are called from processes timed by pclk. */
`timescale 1ns/1ps
module seg_src_model (
   // clock
   input wire logic pclk,
   // select lines
   output logic [7:0] idx0,
   output logic valid0,
   output logic [7:0] idx1,
   output logic valid1,
   // run pins
   output logic trig,
   output logic gate
);
   logic [1:0] hold = '0;
   logic [7:0] v0 = '0;
   logic [7:0] v1 = '0;
   initial begin
      {idx0, idx1, valid0, valid1, trig, gate} = '0;
   end
   // ====================================
   // index lines not being presented flip every cycle, so no stale value
   always @(posedge pclk) begin
      idx0 <= hold[0] ? v0 : ~idx0;
      idx1 <= hold[1] ? v1 : ~idx1;
   end
   // ====================================
   // present the index, then raise the valid line
   task pick(input int ch, input logic [7:0] v);
      @(posedge pclk);
      hold[ch] <= 1'b1;
      if (ch == 0) v0 <= v; else v1 <= v;
      repeat (5) @(posedge pclk);
      if (ch == 0) valid0 <= 1'b1; else valid1 <= 1'b1;
      repeat (4) @(posedge pclk);
      if (ch == 0) valid0 <= 1'b0; else valid1 <= 1'b0;
      @(posedge pclk);
      hold[ch] <= 1'b0;
   endtask
   task pins(input logic t, input logic g);
      @(posedge pclk);
      trig <= t;
      gate <= g;
   endtask
endmodule

// file: verification/waveform_segment_playback_ctrl_bench.sv
/* self-checking bench for wave_seg_play: apb stimulus, read results
   queued and compared by a monitor. assumes ce is held high. */
`timescale 1ns/1ps
module waveform_segment_playback_ctrl_bench;
   import wsp_pkg::*;
   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
   logic [7:0] paddr = '0;
   logic [31:0] pwdata = '0;
   logic [31:0] prdata;
   logic pready, pslverr, playing, valid0, valid1, trig, gate;
   logic [7:0] idx0, idx1, v;
   logic [SMP_W-1:0] smp0, smp1;
   logic [32:0] expq[$];
   logic [31:0] mskq[$];
   logic [11:0] wav[4];
   integer num_errors = 0, checks = 0, seed = 32'hf98d0f0c, n;
   always #12.5 pclk = ~pclk;
   wave_seg_play dut (.pclk(pclk), .presetn(presetn), .ce(1'b1), .paddr(paddr), .psel(psel),
      .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .ext_idx0(idx0), .ext_valid0(valid0), .ext_idx1(idx1),
      .ext_valid1(valid1), .trig_in(trig), .gate_in(gate), .event_in(1'b0),
      .button_in(1'b0), .smp0(smp0), .smp1(smp1), .playing(playing));
   seg_src_model src (.pclk(pclk), .idx0(idx0), .valid0(valid0), .idx1(idx1),
      .valid1(valid1), .trig(trig), .gate(gate));
   // ====================================
   // checking
   task chk(input logic [32:0] got, input logic [32:0] exp);
      checks++;
      if (got !== exp) begin
         num_errors++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   always @(posedge pclk) begin
      if (psel && penable && pready && !pwrite) begin
         chk({pslverr, prdata & mskq.pop_front()}, expq.pop_front());
      end
   end
   task results;
      if (num_errors == 0 && checks > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   initial begin
      #2000000;
      num_errors++;
      results();
   end
   // ====================================
   // stimulus
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d,
      input logic [32:0] e = '0, input logic [31:0] m = '1);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      if (!w) begin
         expq.push_back(e);
         mskq.push_back(m);
      end
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task wait_play(input logic p);
      n = 0;
      while (playing !== p && n < 20) begin
         @(negedge pclk);
         n++;
      end
      chk({32'b0, playing}, {32'b0, p});
   endtask
   task run_len(input int len);
      wait_play(1'b1);
      n = 0;
      while (playing === 1'b1 && n < 60) begin
         @(negedge pclk);
         n++;
      end
      chk(33'(n), 33'(len));
   endtask
   task smp_in(input logic zero);
      repeat (6) @(negedge pclk);
      repeat (8) begin
         @(negedge pclk);
         chk({32'b0, zero ? smp0 === 12'h000 : smp0 inside {wav}}, 33'h1);
      end
   endtask
   task bounds(input int i, input int lo, input int hi);
      apb(1'b1, OFS_TIDX, 32'(i));
      apb(1'b1, OFS_BOUNDS, {16'(hi), 16'(lo)});
   endtask
   initial begin
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      for (int i = 0; i < 4; i++) wav[i] = 12'($random(seed));
      apb(1'b0, OFS_CTRL, 0, 33'h0);
      apb(1'b0, OFS_LOOPS, 0, 33'h1);
      apb(1'b0, 8'h24, 0, 33'h1_0000_0000);
      apb(1'b1, OFS_WADDR, 0);
      for (int i = 0; i < 8; i++) apb(1'b1, OFS_WDATA, 32'(wav[i % 4]));
      bounds(0, 0, 3);
      bounds(1, 4, 7);
      bounds(2, 8, 207);
      apb(1'b0, OFS_BOUNDS, 0, {1'b0, 16'd207, 16'd8});
      smp_in(1'b0);
      apb(1'b1, OFS_CMD, 32'h2);
      wait_play(1'b1);
      apb(1'b1, OFS_CMD, 32'h8);
      smp_in(1'b1);
      bounds(0, 0, 3);
      bounds(2, 8, 207);
      smp_in(1'b0);
      apb(1'b1, OFS_SEG, 32'h2);
      repeat (10) @(posedge pclk);
      apb(1'b1, OFS_SEG, 32'h0);
      apb(1'b0, OFS_STATUS, 0, 33'h8, 32'hfffc);
      apb(1'b1, OFS_CTRL, 32'h10);
      apb(1'b1, OFS_SEG, 32'h3fff);
      apb(1'b0, OFS_STATUS, 0, 33'hfffc, 32'hfffc);
      apb(1'b1, OFS_SEG, 32'h0);
      apb(1'b1, OFS_CTRL, 32'h04);
      wait_play(1'b0);
      // idle address lands one edge after stop, the sample one edge later
      repeat (3) @(negedge pclk);
      chk({21'b0, smp0}, {21'b0, wav[0]});
      apb(1'b1, OFS_CMD, 32'h1);
      wait_play(1'b1);
      apb(1'b1, OFS_CMD, 32'h2);
      wait_play(1'b0);
      apb(1'b1, OFS_LOOPS, 32'h0);
      apb(1'b0, OFS_LOOPS, 0, 33'h1);
      apb(1'b1, OFS_LOOPS, 32'hfffff);
      apb(1'b0, OFS_LOOPS, 0, 33'hf4240);
      for (int s = 1; s < 3; s++) begin
         apb(1'b1, OFS_CTRL, 32'h05 | 32'(s << 5));
         apb(1'b1, OFS_LOOPS, 32'h2);
         apb(1'b1, OFS_CMD, 32'h1);
         wait_play(1'b0);
         if (s == 1) apb(1'b1, OFS_CMD, 32'h4);
         else src.pins(1'b1, 1'b0);
         run_len(8);
         src.pins(1'b0, 1'b0);
      end
      apb(1'b1, OFS_CTRL, 32'h02);
      wait_play(1'b0);
      src.pins(1'b0, 1'b1);
      wait_play(1'b1);
      src.pins(1'b0, 1'b0);
      wait_play(1'b0);
      apb(1'b1, OFS_CTRL, 32'h18);
      apb(1'b0, OFS_STATUS, 0, 33'h0, 32'h3fff_fffc);
      // channels run unsynchronised here, so unequal lengths are allowed
      for (int k = 0; k < 3; k++) begin
         v = (k == 0) ? 8'($random(seed)) : (k == 1 ? 8'h00 : 8'hff);
         src.pick(0, v);
         src.pick(1, ~v);
         repeat (4) @(posedge pclk);
         apb(1'b0, OFS_STATUS, 0, {3'b0, 6'b0, ~v, 6'b0, v, 2'b0}, 32'h3fff_fffc);
      end
      results();
   end
endmodule
